// ==== rtl/cvm_regs.sv ====
// Top: channel gain and silence registers with derived effective settings
`timescale 1ns/1ps
module cvm_regs
    import cvm_pkg::*;
#(
    parameter int TMO_SCALE = CVM_CYC_PER_MS
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata,
    output logic            rvalid,
    input  wire logic       silence_pin,
    input  wire logic [7:0] zero_cross,
    output logic [71:0]     eff_gain_qdb,
    output logic [7:0]      eff_silence
);
    localparam int TW = 23;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [8:0] clamp_q(input logic [8:0] q);
        if (q < CVM_QMIN) begin
            clamp_q = CVM_QMIN;
        end else if (q > CVM_QMAX) begin
            clamp_q = CVM_QMAX;
        end else begin
            clamp_q = q;
        end
    endfunction

    function automatic logic [TW-1:0] tmo_cycles(input logic [2:0] code);
        tmo_cycles = TW'(CVM_TMO_MS[code] * TMO_SCALE);
    endfunction

    typedef struct packed {
        logic [7:0][7:0] gain;
        logic [7:0]      qstep;
        logic [7:0]      sil;
        logic [7:0]      cfg1;
        logic [7:0]      cfg2;
        logic [7:0]      rdata;
        logic            rvalid;
        logic [1:0]      pin_sync;
        logic [7:0]      eff_sil;
        logic [71:0]     eff_gain;
    } cvm_st_t;
    cvm_st_t s_q, s_d;

    logic [7:0][8:0] req_q;
    logic [7:0][8:0] applied;
    logic [1:0][7:0] zx_sync_q;
    logic            pin_act;

    ////////////////////////////////////////////////////////////////////////
    // Request values after pair linking, raw (unclamped) quarter codes
    always_comb begin
        for (int c = 0; c < CVM_NCH; c++) begin
            // Linked higher channel takes the lower's code and quarter bit
            if (c[0] && s_q.cfg1[c >> 1]) begin
                req_q[c] = {s_q.gain[c-1], s_q.qstep[c-1]};
            end else begin
                req_q[c] = {s_q.gain[c], s_q.qstep[c]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel apply engines
    for (genvar g = 0; g < CVM_NCH; g++) begin : g_ch
        cvm_chan #(
            .TW (TW)
        ) u_ch (
            .sys_clk (sys_clk),
            .rstn    (rstn),
            .req_val (req_q[g]),
            .mode    (s_q.cfg2[CVM_POS_MODE +: 2]),
            .tmo_cyc (tmo_cycles(s_q.cfg2[CVM_POS_TMO +: 3])),
            .zero_x  (zx_sync_q[1][g]),
            .applied (applied[g])
        );
    end

    // Zero-cross indications come from the analog side, so synchronise
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            zx_sync_q <= '0;
        end else begin
            zx_sync_q[0] <= zero_cross;
            zx_sync_q[1] <= zx_sync_q[0];
        end
    end

    assign pin_act = s_q.cfg1[CVM_POS_PIN_EN] &&
                     (s_q.pin_sync[1] == s_q.cfg1[CVM_POS_PIN_POL]);

    ////////////////////////////////////////////////////////////////////////
    // Register file and outputs
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        s_d.pin_sync = {s_q.pin_sync[0], silence_pin};
        if (wr_en) begin
            if (addr >= CVM_ADDR_GAIN1 && addr <= CVM_ADDR_GAIN8) begin
                s_d.gain[3'(addr - CVM_ADDR_GAIN1)] = wdata;
            end else begin
                unique case (addr)
                    CVM_ADDR_QSTEP: s_d.qstep = wdata;
                    CVM_ADDR_SIL:   s_d.sil   = wdata;
                    CVM_ADDR_CFG1:  s_d.cfg1  = wdata & CVM_MASK_CFG1;
                    CVM_ADDR_CFG2:  s_d.cfg2  = wdata & CVM_MASK_CFG2;
                    default:        s_d.cfg2  = s_q.cfg2;
                endcase
            end
        end
        if (rd_en) begin
            s_d.rvalid = 1'b1;
            if (addr >= CVM_ADDR_GAIN1 && addr <= CVM_ADDR_GAIN8) begin
                s_d.rdata = s_q.gain[3'(addr - CVM_ADDR_GAIN1)];
            end else begin
                unique case (addr)
                    CVM_ADDR_QSTEP: s_d.rdata = s_q.qstep;
                    CVM_ADDR_SIL:   s_d.rdata = s_q.sil;
                    CVM_ADDR_CFG1:  s_d.rdata = s_q.cfg1;
                    CVM_ADDR_CFG2:  s_d.rdata = s_q.cfg2;
                    default:        s_d.rdata = 8'h00;
                endcase
            end
        end
        for (int c = 0; c < CVM_NCH; c++) begin
            // Silence bypasses zero-cross timing
            if (c[0] && s_q.cfg1[c >> 1]) begin
                s_d.eff_sil[c] = s_q.sil[c-1] | pin_act;
            end else begin
                s_d.eff_sil[c] = s_q.sil[c] | pin_act;
            end
            s_d.eff_gain[c*9 +: 9] = clamp_q(applied[c]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_q.gain     <= {CVM_NCH{CVM_RST_GAIN}};
            s_q.qstep    <= CVM_RST_QSTEP;
            s_q.sil      <= CVM_RST_SIL;
            s_q.cfg1     <= CVM_RST_CFG1;
            s_q.cfg2     <= CVM_RST_CFG2;
            s_q.rdata    <= 8'h00;
            s_q.rvalid   <= 1'b0;
            s_q.pin_sync <= 2'b11;
            s_q.eff_sil  <= 8'h00;
            s_q.eff_gain <= {CVM_NCH{CVM_RST_GAIN, 1'b0}};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata        = s_q.rdata;
    assign rvalid       = s_q.rvalid;
    assign eff_silence  = s_q.eff_sil;
    assign eff_gain_qdb = s_q.eff_gain;
endmodule // cvm_regs

// ==== rtl/cvm_pkg.sv ====
// Package: register map, reset values, field positions and timing constants
package cvm_pkg;
    localparam int          CVM_NCH          = 8;
    localparam logic [7:0]  CVM_ADDR_GAIN1   = 8'h01;
    localparam logic [7:0]  CVM_ADDR_GAIN8   = 8'h08;
    localparam logic [7:0]  CVM_ADDR_QSTEP   = 8'h09;
    localparam logic [7:0]  CVM_ADDR_SIL     = 8'h0a;
    localparam logic [7:0]  CVM_ADDR_CFG1    = 8'h0b;
    localparam logic [7:0]  CVM_ADDR_CFG2    = 8'h0c;
    localparam logic [7:0]  CVM_RST_GAIN     = 8'hd2;
    localparam logic [7:0]  CVM_RST_QSTEP    = 8'h00;
    localparam logic [7:0]  CVM_RST_SIL      = 8'h00;
    localparam logic [7:0]  CVM_RST_CFG1     = 8'h20;
    localparam logic [7:0]  CVM_RST_CFG2     = 8'h0d;
    localparam int          CVM_POS_PIN_EN   = 5;
    localparam int          CVM_POS_PIN_POL  = 4;
    localparam int          CVM_POS_TMO      = 2;
    localparam int          CVM_POS_MODE     = 0;
    localparam logic [7:0]  CVM_MASK_CFG1    = 8'h3f;
    localparam logic [7:0]  CVM_MASK_CFG2    = 8'h1f;
    // Gain in quarter-dB units, offset so the code 0 maps to -96 dB - ...
    // Effective quarter code = 2*code + qbit; limits in the same units
    localparam logic [8:0]  CVM_QMIN         = 9'h024;
    localparam logic [8:0]  CVM_QMAX         = 9'h1fc;
    localparam int          CVM_CLK_HZ       = 100_000_000;
    localparam int          CVM_TMO_MS [8]   = '{5, 10, 15, 18, 20, 30, 40, 50};
    localparam int          CVM_CYC_PER_MS   = CVM_CLK_HZ / 1000;
    typedef enum logic [1:0] {
        CVM_ZC_NOW  = 2'b00,
        CVM_ZC_DROP = 2'b01,
        CVM_ZC_PUSH = 2'b10,
        CVM_ZC_RSV  = 2'b11
    } cvm_zc_t;
endpackage

// ==== rtl/cvm_chan.sv ====
// One channel's zero-cross apply logic: pending value, deadline timer
`timescale 1ns/1ps
module cvm_chan
    import cvm_pkg::*;
#(
    parameter int TW = 23
) (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic [8:0]    req_val,
    input  wire logic [1:0]    mode,
    input  wire logic [TW-1:0] tmo_cyc,
    input  wire logic          zero_x,
    output logic [8:0]         applied
);
    typedef struct packed {
        logic [8:0]    app;
        logic [8:0]    pend;
        logic          busy;
        logic [TW-1:0] cnt;
        logic [8:0]    last;
    } cvm_chs_t;
    cvm_chs_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (s_q.busy) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        if (s_q.busy && (zero_x || s_q.cnt >= tmo_cyc)) begin
            s_d.app  = s_q.pend;
            s_d.busy = 1'b0;
        end
        if (req_val != s_q.last) begin
            s_d.last = req_val;
            unique case (mode)
                CVM_ZC_NOW, CVM_ZC_RSV: begin
                    // Reserved code handled as immediate, safest choice
                    s_d.app  = req_val;
                    s_d.busy = 1'b0;
                end
                CVM_ZC_DROP: begin
                    // Older pending value simply overwritten
                    s_d.pend = req_val;
                    s_d.busy = 1'b1;
                    s_d.cnt  = '0;
                end
                CVM_ZC_PUSH: begin
                    if (s_q.busy) begin
                        s_d.app = s_q.pend;
                    end
                    s_d.pend = req_val;
                    s_d.busy = 1'b1;
                    s_d.cnt  = '0;
                end
            endcase
        end else if (mode == CVM_ZC_NOW) begin
            if (s_q.busy) begin
                s_d.app  = s_q.pend;
                s_d.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_q.app  <= {CVM_RST_GAIN, 1'b0};
            s_q.pend <= {CVM_RST_GAIN, 1'b0};
            s_q.last <= {CVM_RST_GAIN, 1'b0};
            s_q.busy <= 1'b0;
            s_q.cnt  <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign applied = s_q.app;
endmodule // cvm_chan

// ==== bench/cvm_zx_src.sv ====
// Partner model: analog front end issuing per-channel zero-crossing pulses
`timescale 1ns/1ps
module cvm_zx_src (
    input  wire logic       sys_clk,
    input  wire logic [7:0] fire,
    output logic [7:0]      zero_cross
);
    logic [1:0] left_q;
    initial begin
        zero_cross = 8'h00;
        left_q     = 2'h0;
    end
    // Held several cycles so the 2-flop synchroniser cannot miss a crossing
    always @(posedge sys_clk) begin
        if (fire != 8'h00) begin
            zero_cross <= fire;
            left_q     <= 2'h3;
        end else if (left_q != 2'h0) begin
            left_q <= left_q - 2'h1;
        end else begin
            zero_cross <= 8'h00;
        end
    end
endmodule // cvm_zx_src

// ==== bench/cvm_regs_sva.sv ====
// Checker: port-level properties of the register block
`timescale 1ns/1ps
module cvm_regs_sva (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        rvalid,
    input wire logic        silence_pin,
    input wire logic [71:0] eff_gain_qdb,
    input wire logic [7:0]  eff_silence
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_reset_state: assert property ($rose(rstn) |-> eff_silence == 8'h00 && !rvalid
        && eff_gain_qdb == {8{9'h1a4}}) else $error("reset state wrong");
    chk_read_ack: assert property (rd_en |=> rvalid) else $error("read not answered");
    chk_rvalid_cause: assert property (rvalid |-> $past(rd_en)) else $error("stray rvalid");
    chk_rdata_hold: assert property (!rd_en |=> $stable(rdata)) else $error("rdata moved");
    chk_gain_floor: assert property (eff_gain_qdb[8:0] >= 9'h024 && eff_gain_qdb[8:0] <= 9'h1fc)
        else $error("lane 0 gain out of range");
    chk_gain_ceil: assert property (eff_gain_qdb[71:63] >= 9'h024 && eff_gain_qdb[71:63] <= 9'h1fc)
        else $error("lane 7 gain out of range");
    chk_silence_all: assert property (wr_en && addr == 8'h0a && wdata == 8'hff |-> ##2
        eff_silence == 8'hff) else $error("silence bits not applied");
    // Silence only moves on a write or a pin change
    chk_sil_steady: assert property ((!wr_en && $stable(silence_pin))[*5] |=>
        $stable(eff_silence)) else $error("silence changed without cause");
endmodule // cvm_regs_sva
bind cvm_regs cvm_regs_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .silence_pin(silence_pin),
    .eff_gain_qdb(eff_gain_qdb), .eff_silence(eff_silence));

// ==== bench/tb_top.sv ====
// Testbench: register block with zero-cross source model
`timescale 1ns/1ps
module tb_top;
    import cvm_pkg::*;
    logic        sys_clk, rstn, wr_en, rd_en, silence_pin, rvalid, on;
    logic [7:0]  addr, wdata, rdata, eff_silence, zero_cross, fire, qb, sb, cf;
    logic [71:0] eff_gain_qdb;
    logic [7:0]  q[$];
    logic [7:0]  gs[8];
    int          fail_count, n_compared, lc;
    cvm_regs #(.TMO_SCALE(10)) uut (.sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
        .silence_pin(silence_pin), .zero_cross(zero_cross), .eff_gain_qdb(eff_gain_qdb),
        .eff_silence(eff_silence));
    cvm_zx_src zx (.sys_clk(sys_clk), .fire(fire), .zero_cross(zero_cross));
    ////////////////////////////////////////////////////////////////
    task automatic cmp(string n, logic [8:0] e, logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge sys_clk);
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge sys_clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge sys_clk);
        rd_en = 1'b1;
        addr  = a;
        q.push_back(e);
        @(negedge sys_clk);
        rd_en = 1'b0;
    endtask
    function automatic logic [8:0] eg(logic [7:0] c, logic b);
        int v;
        v = 2 * c + b;
        return (v < 36) ? 9'h024 : (v > 508) ? 9'h1fc : 9'(v);
    endfunction
    task automatic ckg(int c, logic [8:0] e);
        cmp("gain", e, eff_gain_qdb[c*9 +: 9]);
    endtask
    task automatic end_sim;
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rvalid === 1'b1) begin
            cmp("rdata", {1'b0, q.pop_front()}, {1'b0, rdata});
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        end_sim();
    end
    initial begin
        {rstn, wr_en, rd_en, addr, wdata, fire} = '0;
        silence_pin = 1'b1;
        lc = $urandom(32'h732de150);
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        for (int a = 1; a <= 8; a++) rd(8'(a), 8'hd2);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h20);
        rd(8'h0c, 8'h0d);
        rd(8'h0f, 8'h00);
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'h3f);
        // Immediate mode; edge codes 00 and ff exercise the clamp
        wr(8'h0c, 8'h00);
        wr(8'h0b, 8'h00);
        qb = $urandom;
        wr(8'h09, qb);
        for (int c = 0; c < 8; c++) gs[c] = (c == 0) ? 8'h00 : (c == 7) ? 8'hff : $urandom;
        for (int c = 0; c < 8; c++) wr(8'(c + 1), gs[c]);
        repeat (4) @(negedge sys_clk);
        for (int c = 0; c < 8; c++) ckg(c, eg(gs[c], qb[c]));
        rd(8'h05, gs[4]);
        for (int k = 0; k < 4; k++) begin
            sb = $urandom;
            wr(8'h0a, sb);
            wr(8'h0b, 8'(1 << k));
            repeat (4) @(negedge sys_clk);
            for (int c = 0; c < 8; c++) begin
                lc = ((c >> 1) == k) ? (c & 6) : c;
                ckg(c, eg(gs[lc], qb[lc]));
                cmp("silence", {1'b0, sb[lc]}, {1'b0, eff_silence[c]});
            end
        end
        // Every enable, polarity and pin level combination
        for (int i = 0; i < 8; i++) begin
            cf = {2'b00, i[1], i[0], 4'h0};
            on = i[1] && (i[2] == i[0]);
            wr(8'h0b, cf);
            silence_pin = i[2];
            repeat (5) @(negedge sys_clk);
            cmp("silence", {1'b0, on ? 8'hff : sb}, {1'b0, eff_silence});
        end
        wr(8'h0a, 8'hff);
        repeat (3) @(negedge sys_clk);
        cmp("silence", 9'h0ff, {1'b0, eff_silence});
        wr(8'h09, 8'h00);
        wr(8'h0c, 8'h01);
        wr(8'h01, 8'h80);
        repeat (20) @(negedge sys_clk);
        ckg(0, eg(8'h00, 1'b0));
        fire = 8'h01;
        @(negedge sys_clk);
        fire = 8'h00;
        repeat (8) @(negedge sys_clk);
        ckg(0, eg(8'h80, 1'b0));
        wr(8'h01, 8'h90);
        repeat (10) @(negedge sys_clk);
        wr(8'h01, 8'ha0);
        repeat (40) @(negedge sys_clk);
        ckg(0, eg(8'h80, 1'b0));
        repeat (20) @(negedge sys_clk);
        ckg(0, eg(8'ha0, 1'b0));
        wr(8'h0c, 8'h02);
        wr(8'h01, 8'h40);
        repeat (5) @(negedge sys_clk);
        wr(8'h01, 8'h50);
        repeat (5) @(negedge sys_clk);
        ckg(0, eg(8'h40, 1'b0));
        repeat (60) @(negedge sys_clk);
        ckg(0, eg(8'h50, 1'b0));
        wr(8'h0c, 8'h1d);
        wr(8'h01, 8'h60);
        repeat (450) @(negedge sys_clk);
        ckg(0, eg(8'h50, 1'b0));
        repeat (70) @(negedge sys_clk);
        ckg(0, eg(8'h60, 1'b0));
        // Reserved mode code behaves as immediate
        wr(8'h0c, 8'h03);
        wr(8'h01, 8'h70);
        repeat (4) @(negedge sys_clk);
        ckg(0, eg(8'h70, 1'b0));
        end_sim();
    end
endmodule // tb_top
